// ===== inc/ctr_defs.vh
// Constants for the camera trigger command interpreter and its timing.
// Assumes a 100 MHz clk; all framing characters are plain ASCII.
`ifndef CTR_DEFS_VH
`define CTR_DEFS_VH
// Framing characters
`define CTR_CH_START 8'h40
`define CTR_CH_END 8'h21
// Command codes in the header byte
`define CTR_CMD_NULL 8'h00
`define CTR_CMD_READ 8'h01
`define CTR_CMD_WRITE 8'h02
// Status codes in the response header byte
`define CTR_ST_OK 8'h00
`define CTR_ST_ERR 8'h01
// Hex characters in a frame between start and end
`define CTR_FRAME_NIBS 4'hE
`define CTR_LAST_TX_IDX 4'hF
// Register addresses
`define CTR_A_CTRL_STATUS 8'h00
`define CTR_A_CAMERA_CONTROL 8'h01
`define CTR_A_UNIT_SPARE 8'h02
`define CTR_A_FRAME_PERIOD 8'h03
`define CTR_A_CAM0_COUNT 8'h04
`define CTR_A_CAM1_COUNT 8'h05
`define CTR_A_CAM2_COUNT 8'h06
`define CTR_A_CAM3_COUNT 8'h07
`define CTR_A_FLASH_ENABLES 8'h08
`define CTR_A_FLASH_TIMING 8'h09
`define CTR_A_CAMERA_POWER 8'hFE
`define CTR_A_FW_DATE 8'hFF
// Field positions
`define CTR_F_GLOBAL_EN 0
`define CTR_F_BUSY_CLEAR 1
`define CTR_F_CAM_EN_LSB 0
`define CTR_F_MAN_TRIG_LSB 4
`define CTR_F_DELAY_LSB 16
`define CTR_F_DUR_LSB 0
// Reset values
`define CTR_RST_FRAME_PERIOD 20'h1_5B4
`define CTR_RST_ACQ_COUNT 20'hF_FFFF
// Firmware date code; the value is arbitrary
`define CTR_FW_DATE_CODE 32'h0101_0101
// Timebase: 1 us tick derived from the 10 ns clock
`define CTR_TICK_NS 1000
`define CTR_CLK_NS 10
`define CTR_TICK_CYC (`CTR_TICK_NS / `CTR_CLK_NS)
// Last count of the 100-cycle divider, sized for its 7-bit counter
`define CTR_TICK_LAST 7'h63
`endif

// ===== rtl/ctr_timing.v
// Frame timer, per-camera frame acquire pulses and flash delay/duration.
// Assumes configuration inputs are stable flops in the same clk domain.
`include "ctr_defs.vh"
module ctr_timing (
	input wire clk,
	input wire rst,
	input wire global_en,
	input wire [3:0] cam_en,
	input wire [3:0] flash_en,
	input wire [19:0] frame_period,
	input wire [79:0] acq_counts,
	input wire [8:0] flash_delay,
	input wire [8:0] flash_dur,
	output reg [3:0] frame_acquire,
	output reg [3:0] flash_enable
);
	localparam [6:0] TICK_LAST = `CTR_TICK_LAST;
	reg [6:0] tick_cnt;
	reg [19:0] timer;
	reg [8:0] delay_left [0:3];
	reg [8:0] dur_left [0:3];
	wire tick = (tick_cnt == TICK_LAST);
	wire [19:0] next_timer = (timer >= frame_period) ? 20'h0_0000 : timer + 20'h0_0001;
	integer i;

	// Microsecond timebase and frame timer with wrap at the period
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			tick_cnt <= 7'h00;
			timer <= 20'h0_0000;
		end else begin
			tick_cnt <= tick ? 7'h00 : tick_cnt + 7'h01;
			if (tick)
				timer <= next_timer;
		end
	end

	// Acquire pulse lasts one microsecond; flash follows after a delay
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			frame_acquire <= 4'h0;
			flash_enable <= 4'h0;
			for (i = 0; i < 4; i = i + 1) begin
				delay_left[i] <= 9'h000;
				dur_left[i] <= 9'h000;
			end
		end else begin
			for (i = 0; i < 4; i = i + 1) begin
				if (!(global_en && cam_en[i])) begin
					frame_acquire[i] <= 1'b0;
					flash_enable[i] <= 1'b0;
					delay_left[i] <= 9'h000;
					dur_left[i] <= 9'h000;
				end else if (tick) begin
					// Count above the period never matches the timer
					frame_acquire[i] <= (next_timer == acq_counts[i*20 +: 20]);
					if (next_timer == acq_counts[i*20 +: 20]) begin
						delay_left[i] <= flash_delay;
						dur_left[i] <= (flash_delay == 9'h000) ? flash_dur : 9'h000;
						flash_enable[i] <= flash_en[i] && (flash_delay == 9'h000)
							&& (flash_dur != 9'h000);
					end else if (delay_left[i] != 9'h000) begin
						delay_left[i] <= delay_left[i] - 9'h001;
						if (delay_left[i] == 9'h001) begin
							dur_left[i] <= flash_dur;
							flash_enable[i] <= flash_en[i] && (flash_dur != 9'h000);
						end
					end else if (dur_left[i] != 9'h000) begin
						dur_left[i] <= dur_left[i] - 9'h001;
						if (dur_left[i] == 9'h001)
							flash_enable[i] <= 1'b0;
					end
					if (!flash_en[i])
						flash_enable[i] <= 1'b0;
				end
			end
		end
	end
endmodule

// ===== rtl/ctr_cmd_regs.v
// Command interpreter and configuration registers of the trigger controller.
// Assumes rx/tx characters come from a byte-wide serial bridge on clk.
//
// Notes on behaviour
// - Frames start with 0x40, end with 0x21; header, address, four payload bytes, checksum.
// - Command header 0x00 is null, 0x01 reads, 0x02 writes a register.
// - Response header carries 0x00 for accepted, 0x01 for error.
// - Checksum is the 8-bit sum of header, address and payload bytes.
// - Exactly one response is sent for each command received, rejected ones included.
// - Read ignores payload except checksum; reply echoes address with register contents.
// - Valid write stores payload; reply echoes address and data with fresh checksum.
// - Wrong payload length is not executed; reply is error with zero fields.
// - Console pins route serial port: top low selects microcontroller, 1000-1011 cameras.
// - Writing one to busy-clear clears busy; any trigger event sets busy.
// - Global enable low holds all frame acquire and flash outputs negated; camera power and manual triggers are not gated.
// - Manual trigger bits 7..4 force a trigger on cameras 3..0.
// - Camera enable bits 3..0 gate each camera's frame and flash outputs.
// - Frame period is a 20-bit microsecond cycle time; host avoids values below 0x15B4.
// - Frame timer advances one count per microsecond.
// - Acquire output is true for one microsecond when timer equals camera count.
// - Counts above the period never match, disabling that camera.
// - Flash enable bits 3..0 enable or disable each flash output.
// - Flash delay bits 24..16 set microseconds from frame enable to flash.
// - Flash duration bits 8..0 set how long flash stays true.
// - Camera power bits 3..0 switch each camera supply on or off.
// - Firmware register returns BCD serial, month, day and year bytes.
// - Frame timer resets to zero and wraps at the period count.
`include "ctr_defs.vh"
module ctr_cmd_regs (
	input wire clk,
	input wire rst,
	input wire [7:0] rx_data,
	input wire rx_valid,
	output reg rx_ready,
	output reg [7:0] tx_data,
	output reg tx_valid,
	input wire tx_ready,
	input wire [3:0] console_select_pins,
	output reg console_sel_mcu,
	output reg [3:0] console_sel_cam,
	input wire [3:0] trigger_sources,
	output reg busy,
	output reg [3:0] cam_manual_trigger,
	output reg [3:0] cam_power,
	output wire [3:0] frame_acquire,
	output wire [3:0] flash_enable
);
	// Parser states
	localparam [3:0] S_HUNT = 4'b0001;
	localparam [3:0] S_RECV = 4'b0010;
	localparam [3:0] S_SEND = 4'b0100;
	localparam [3:0] S_WAIT = 4'b1000;

	reg [3:0] state;
	reg [55:0] rx_buf;
	reg [3:0] rx_cnt;
	reg rx_over;
	reg rx_bad;
	reg [55:0] resp;
	reg [3:0] tx_idx;

	// Configuration registers
	reg global_en;
	reg [3:0] cam_en;
	reg [19:0] frame_period;
	reg [19:0] acq_cnt [0:3];
	reg [3:0] flash_en;
	reg [8:0] flash_delay;
	reg [8:0] flash_dur;

	// Converts an ASCII hex character; bit 4 flags a valid digit
	// Lower-case digits are taken as well, so hosts may send either case
	function [4:0] hex_to_nib;
		input [7:0] c;
		begin
			if (c >= 8'h30 && c <= 8'h39)
				hex_to_nib = {1'b1, c[3:0]};
			else if ((c >= 8'h41 && c <= 8'h46) || (c >= 8'h61 && c <= 8'h66))
				hex_to_nib = {1'b1, c[3:0] + 4'h9};
			else
				hex_to_nib = 5'h00;
		end
	endfunction

	// Converts a nibble to an upper-case ASCII hex character
	// Replies always use upper case, whatever case the command used
	function [7:0] nib_to_hex;
		input [3:0] n;
		begin
			if (n < 4'hA)
				nib_to_hex = {4'h3, n};
			else
				nib_to_hex = {4'h4, n - 4'h9};
		end
	endfunction

	// Eight-bit truncated sum of header, address and payload
	// Carries out of bit 7 are dropped by the function's own width
	function [7:0] frame_sum;
		input [47:0] f;
		begin
			frame_sum = f[47:40] + f[39:32] + f[31:24] + f[23:16] + f[15:8] + f[7:0];
		end
	endfunction

	// Register readback; reserved bits and addresses read zero
	function [31:0] read_reg;
		input [7:0] a;
		begin
			read_reg = 32'h0000_0000;
			case (a)
			`CTR_A_CTRL_STATUS: begin
				read_reg[`CTR_F_GLOBAL_EN] = global_en;
				read_reg[`CTR_F_BUSY_CLEAR] = busy; // Busy state reads back
			end
			// Manual trigger bits are write-only and read back as zero
			`CTR_A_CAMERA_CONTROL: read_reg[3:0] = cam_en;
			`CTR_A_FRAME_PERIOD: read_reg[19:0] = frame_period;
			`CTR_A_CAM0_COUNT: read_reg[19:0] = acq_cnt[0];
			`CTR_A_CAM1_COUNT: read_reg[19:0] = acq_cnt[1];
			`CTR_A_CAM2_COUNT: read_reg[19:0] = acq_cnt[2];
			`CTR_A_CAM3_COUNT: read_reg[19:0] = acq_cnt[3];
			`CTR_A_FLASH_ENABLES: read_reg[3:0] = flash_en;
			`CTR_A_FLASH_TIMING: begin
				read_reg[`CTR_F_DELAY_LSB +: 9] = flash_delay;
				read_reg[`CTR_F_DUR_LSB +: 9] = flash_dur;
			end
			`CTR_A_CAMERA_POWER: read_reg[3:0] = cam_power;
			`CTR_A_FW_DATE: read_reg = `CTR_FW_DATE_CODE;
			default: read_reg = 32'h0000_0000;
			endcase
		end
	endfunction

	// Fields of the captured command
	wire [7:0] cmd_hdr = rx_buf[55:48];
	wire [7:0] cmd_addr = rx_buf[47:40];
	wire [31:0] cmd_data = rx_buf[39:8];
	wire [7:0] cmd_sum = rx_buf[7:0];
	wire [4:0] rx_nib = hex_to_nib(rx_data);
	wire rx_take = rx_valid && rx_ready;
	wire frame_done = rx_take && (state == S_RECV) && (rx_data == `CTR_CH_END);
	// Short, overlong or non-hex frames all fail the length
	wire len_ok = (rx_cnt == `CTR_FRAME_NIBS) && !rx_over && !rx_bad;
	wire sum_ok = (frame_sum(rx_buf[55:8]) == cmd_sum);
	wire cmd_ok = len_ok && sum_ok && (cmd_hdr == `CTR_CMD_NULL
		|| cmd_hdr == `CTR_CMD_READ || cmd_hdr == `CTR_CMD_WRITE);
	wire do_write = frame_done && cmd_ok && (cmd_hdr == `CTR_CMD_WRITE);

	// Response built from the captured command
	// Latched at the end character, so nothing received later can disturb it
	reg [55:0] next_resp;
	always @* begin
		next_resp = 56'h00_0000_0000_0000;
		if (!cmd_ok) begin
			// Error reply carries zeros and the matching checksum
			next_resp[55:48] = `CTR_ST_ERR;
			next_resp[7:0] = frame_sum({`CTR_ST_ERR, 40'h00_0000_0000});
		end else begin
			next_resp[55:48] = `CTR_ST_OK;
			next_resp[47:40] = cmd_addr;
			if (cmd_hdr == `CTR_CMD_READ)
				next_resp[39:8] = read_reg(cmd_addr);
			else if (cmd_hdr == `CTR_CMD_WRITE)
				next_resp[39:8] = cmd_data;
			next_resp[7:0] = frame_sum(next_resp[55:8]);
		end
	end

	// Character selected for the current transmit slot
	reg [7:0] next_tx_char;
	always @* begin
		if (tx_idx == 4'h0)
			next_tx_char = `CTR_CH_START;
		else if (tx_idx == `CTR_LAST_TX_IDX)
			next_tx_char = `CTR_CH_END;
		else
			next_tx_char = nib_to_hex(resp[(4'hE - tx_idx) * 4 +: 4]);
	end

	// Frame parser and response sender
	// rx_ready stays low from the end character until the last reply char is taken,
	// so a host that sends early cannot overrun the single frame buffer
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			state <= S_HUNT;
			rx_buf <= 56'h00_0000_0000_0000;
			rx_cnt <= 4'h0;
			rx_over <= 1'b0;
			rx_bad <= 1'b0;
			resp <= 56'h00_0000_0000_0000;
			tx_idx <= 4'h0;
			tx_data <= 8'h00;
			tx_valid <= 1'b0;
			rx_ready <= 1'b1;
		end else begin
			case (state)
			S_HUNT: begin
				if (rx_take && rx_data == `CTR_CH_START) begin
					state <= S_RECV;
					rx_cnt <= 4'h0;
					rx_over <= 1'b0;
					rx_bad <= 1'b0;
					rx_buf <= 56'h00_0000_0000_0000;
				end
			end
			S_RECV: begin
				if (rx_take) begin
					if (rx_data == `CTR_CH_START) begin
						// A new start restarts the frame
						rx_cnt <= 4'h0;
						rx_over <= 1'b0;
						rx_bad <= 1'b0;
						rx_buf <= 56'h00_0000_0000_0000;
					end else if (rx_data == `CTR_CH_END) begin
						// Every completed frame gets one reply
						resp <= next_resp;
						tx_idx <= 4'h0;
						rx_ready <= 1'b0;
						state <= S_SEND;
					end else if (!rx_nib[4]) begin
						rx_bad <= 1'b1;
					end else if (rx_cnt == `CTR_FRAME_NIBS) begin
						rx_over <= 1'b1; // Too many characters
					end else begin
						rx_buf <= {rx_buf[51:0], rx_nib[3:0]};
						rx_cnt <= rx_cnt + 4'h1;
					end
				end
			end
			S_SEND: begin
				tx_data <= next_tx_char;
				tx_valid <= 1'b1;
				state <= S_WAIT;
			end
			S_WAIT: begin
				if (tx_ready) begin
					tx_valid <= 1'b0;
					if (tx_idx == `CTR_LAST_TX_IDX) begin
						state <= S_HUNT;
						rx_ready <= 1'b1;
					end else begin
						tx_idx <= tx_idx + 4'h1;
						state <= S_SEND;
					end
				end
			end
			default: begin
				state <= S_HUNT;
				rx_ready <= 1'b1;
				tx_valid <= 1'b0;
			end
			endcase
		end
	end

	// Register writes from accepted write commands
	// Only a frame that passed length, checksum and header checks gets here
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			global_en <= 1'b0;
			cam_en <= 4'h0;
			frame_period <= `CTR_RST_FRAME_PERIOD;
			acq_cnt[0] <= `CTR_RST_ACQ_COUNT;
			acq_cnt[1] <= `CTR_RST_ACQ_COUNT;
			acq_cnt[2] <= `CTR_RST_ACQ_COUNT;
			acq_cnt[3] <= `CTR_RST_ACQ_COUNT;
			flash_en <= 4'h0;
			flash_delay <= 9'h000;
			flash_dur <= 9'h000;
			cam_power <= 4'h0;
		end else if (do_write) begin
			case (cmd_addr)
			`CTR_A_CTRL_STATUS: global_en <= cmd_data[`CTR_F_GLOBAL_EN];
			`CTR_A_CAMERA_CONTROL: cam_en <= cmd_data[`CTR_F_CAM_EN_LSB +: 4];
			`CTR_A_FRAME_PERIOD: frame_period <= cmd_data[19:0];
			`CTR_A_CAM0_COUNT: acq_cnt[0] <= cmd_data[19:0];
			`CTR_A_CAM1_COUNT: acq_cnt[1] <= cmd_data[19:0];
			`CTR_A_CAM2_COUNT: acq_cnt[2] <= cmd_data[19:0];
			`CTR_A_CAM3_COUNT: acq_cnt[3] <= cmd_data[19:0];
			`CTR_A_FLASH_ENABLES: flash_en <= cmd_data[3:0];
			`CTR_A_FLASH_TIMING: begin
				flash_delay <= cmd_data[`CTR_F_DELAY_LSB +: 9];
				flash_dur <= cmd_data[`CTR_F_DUR_LSB +: 9];
			end
			`CTR_A_CAMERA_POWER: cam_power <= cmd_data[3:0];
			default: global_en <= global_en; // Reserved: no effect
			endcase
		end
	end

	// Manual triggers pulse for one cycle; busy set wins over clear
	// A trigger in the same cycle as a clear keeps busy set, so no event is lost
	wire man_write = do_write && (cmd_addr == `CTR_A_CAMERA_CONTROL);
	wire [3:0] man_bits = man_write ? cmd_data[`CTR_F_MAN_TRIG_LSB +: 4] : 4'h0;
	wire busy_clr = do_write && (cmd_addr == `CTR_A_CTRL_STATUS)
		&& cmd_data[`CTR_F_BUSY_CLEAR];
	wire any_trigger = (|trigger_sources) || (|man_bits);
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			cam_manual_trigger <= 4'h0;
			busy <= 1'b0;
		end else begin
			cam_manual_trigger <= man_bits;
			if (any_trigger)
				busy <= 1'b1;
			else if (busy_clr)
				busy <= 1'b0;
		end
	end

	// Console routing from the select pins; microcontroller by default
	// The route follows the pins one clock later; codes 11xx select no port
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			console_sel_mcu <= 1'b1;
			console_sel_cam <= 4'h0;
		end else begin
			console_sel_mcu <= !console_select_pins[3];
			if (console_select_pins[3] && !console_select_pins[2])
				console_sel_cam <= 4'h1 << console_select_pins[1:0];
			else
				console_sel_cam <= 4'h0;
		end
	end

	// Frame timer, acquire and flash generation
	// Camera power and manual triggers bypass the global enable on purpose
	ctr_timing u_timing (
		.clk(clk),
		.rst(rst),
		.global_en(global_en),
		.cam_en(cam_en),
		.flash_en(flash_en),
		.frame_period(frame_period),
		.acq_counts({acq_cnt[3], acq_cnt[2], acq_cnt[1], acq_cnt[0]}),
		.flash_delay(flash_delay),
		.flash_dur(flash_dur),
		.frame_acquire(frame_acquire),
		.flash_enable(flash_enable)
	);
endmodule

// ===== tb/ctr_cmd_regs_asserts.sv
// Port checker for the command interpreter.
// Assumes one clk domain with async active-high rst.
module ctr_cmd_regs_asserts (
	input wire clk,
	input wire rst,
	input wire [7:0] rx_data,
	input wire rx_valid,
	input wire rx_ready,
	input wire [7:0] tx_data,
	input wire tx_valid,
	input wire tx_ready,
	input wire [3:0] console_select_pins,
	input wire console_sel_mcu,
	input wire [3:0] console_sel_cam,
	input wire [3:0] trigger_sources,
	input wire busy,
	input wire [3:0] cam_manual_trigger,
	input wire [3:0] cam_power,
	input wire [3:0] frame_acquire,
	input wire [3:0] flash_enable
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] acq_len;
	// Cycles the camera 0 acquire pulse has been high
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			acq_len <= 8'h00;
		else if (frame_acquire[0])
			acq_len <= acq_len + 8'h01;
		else
			acq_len <= 8'h00;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	a_tx_char_holds: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
		else $error("reply char changed before taken");
	a_tx_char_gap: assert property (tx_valid && tx_ready |=> !tx_valid)
		else $error("no gap after reply char");
	a_rx_locked: assert property (tx_valid |-> !rx_ready)
		else $error("accepting chars during reply");
	a_ready_back: assert property (tx_valid && tx_ready && tx_data == 8'h21 |=> rx_ready)
		else $error("rx not reopened after reply");
	a_reply_start: assert property ($fell(rx_ready) |-> ##[1:2] (tx_valid && tx_data == 8'h40))
		else $error("reply does not open with start char");
	a_console_mcu: assert property (!console_select_pins[3] && $stable(console_select_pins)
		|=> console_sel_mcu && console_sel_cam == 4'h0)
		else $error("controller console not selected");
	a_console_cam: assert property (console_select_pins[3:2] == 2'b10 && $stable(console_select_pins)
		|=> !console_sel_mcu && console_sel_cam == (4'h1 << $past(console_select_pins[1:0])))
		else $error("wrong camera console selected");
	a_busy_set: assert property (|trigger_sources |=> busy)
		else $error("trigger did not set busy");
	a_manual_pulse: assert property (cam_manual_trigger[0] |=> !cam_manual_trigger[0])
		else $error("manual trigger longer than a cycle");
	a_acq_width: assert property ($fell(frame_acquire[0]) |-> acq_len == 8'h64)
		else $error("acquire pulse not one microsecond");
	c_reply_end: cover property (tx_valid && tx_ready && tx_data == 8'h21);
	c_acquire: cover property ($rose(frame_acquire[0]));
	c_flash: cover property ($rose(flash_enable[0]));
endmodule
bind ctr_cmd_regs ctr_cmd_regs_asserts chk_u (.clk(clk), .rst(rst), .rx_data(rx_data),
	.rx_valid(rx_valid), .rx_ready(rx_ready), .tx_data(tx_data), .tx_valid(tx_valid),
	.tx_ready(tx_ready), .console_select_pins(console_select_pins),
	.console_sel_mcu(console_sel_mcu), .console_sel_cam(console_sel_cam),
	.trigger_sources(trigger_sources), .busy(busy), .cam_manual_trigger(cam_manual_trigger),
	.cam_power(cam_power), .frame_acquire(frame_acquire), .flash_enable(flash_enable));

// ===== tb/ctr_host_model.sv
// Host side of the serial link: sends command chars, sinks reply chars.
// Assumes the interpreter's valid/ready char handshake on clk.
module ctr_host_model (
	input wire clk,
	output logic [7:0] rx_data,
	output logic rx_valid,
	input wire rx_ready,
	input wire [7:0] tx_data,
	input wire tx_valid,
	output logic tx_ready
);
	timeunit 1ns;
	timeprecision 100ps;
	logic slow = 1'b0;
	logic [1:0] ph = 2'b00;
	initial begin
		rx_data = 8'h00;
		rx_valid = 1'b0;
	end
	// Sink stalls three cycles of four when slow
	always @(posedge clk) begin
		ph <= ph + 2'b01;
		tx_ready <= #1 !slow || ph == 2'b11;
	end
	// One char per accepted edge, then collect up to 16 reply chars
	task automatic xchg(input string s, output string r);
		r = "";
		@(posedge clk);
		foreach (s[i]) begin
			#1 rx_data = s[i];
			rx_valid = 1'b1;
			@(posedge clk);
			while (rx_ready !== 1'b1) @(posedge clk);
		end
		// Released line shows the inverse of the last char
		#1 rx_valid = 1'b0;
		rx_data = ~rx_data;
		for (int n = 0; n < 4000 && r.len() < 16; n++) begin
			@(posedge clk);
			if (tx_valid === 1'b1 && tx_ready === 1'b1)
				r = {r, string'(tx_data)};
		end
	endtask
endmodule

// ===== tb/camera_trigger_cmd_regs_tb_top.sv
// Bench top: command sequences through the host model, output checks.
// Assumes the interpreter with its timing block on a 100 MHz clk.
`include "ctr_defs.vh"
module camera_trigger_cmd_regs_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [3:0] console_select_pins = 4'h0;
	logic [3:0] trigger_sources = 4'h0;
	wire [7:0] rx_data, tx_data;
	wire rx_valid, rx_ready, tx_valid, tx_ready, console_sel_mcu, busy;
	wire [3:0] console_sel_cam, cam_manual_trigger, cam_power, frame_acquire, flash_enable;
	int error_cnt = 0;
	int checked = 0;
	int cyc = 0;
	int t_rise [8];
	wire [7:0] mon;
	logic [7:0] mon_q = 8'hFF;
	logic [7:0] wa [7] = '{8'h03, 8'h05, 8'h08, 8'h09, 8'hFE, 8'h02, 8'h0A};
	logic [31:0] wm [7] = '{32'h000F_FFFF, 32'h000F_FFFF, 32'h0000_000F, 32'h01FF_01FF,
		32'h0000_000F, 32'h0000_0000, 32'h0000_0000};
	logic [7:0] ca [7] = '{8'h03, 8'h04, 8'h05, 8'h06, 8'h08, 8'h09, 8'h01};
	logic [31:0] cd [7] = '{32'h0000_15B4, 32'h0000_012C, 32'h0000_0136, 32'h0000_00FA,
		32'h0000_0001, 32'h0003_0002, 32'h0000_001F};
	initial forever #5 clk = ~clk;
	ctr_cmd_regs dut_u (.clk(clk), .rst(rst), .rx_data(rx_data), .rx_valid(rx_valid),
		.rx_ready(rx_ready), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
		.console_select_pins(console_select_pins), .console_sel_mcu(console_sel_mcu),
		.console_sel_cam(console_sel_cam), .trigger_sources(trigger_sources), .busy(busy),
		.cam_manual_trigger(cam_manual_trigger), .cam_power(cam_power),
		.frame_acquire(frame_acquire), .flash_enable(flash_enable));
	ctr_host_model host_u (.clk(clk), .rx_data(rx_data), .rx_valid(rx_valid),
		.rx_ready(rx_ready), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready));
	// First rising edge of each watched output, in cycles
	assign mon = {cam_manual_trigger[0], flash_enable[1], ~flash_enable[0], flash_enable[0],
		frame_acquire};
	always @(posedge clk) begin
		cyc <= cyc + 1;
		mon_q <= mon;
		for (int i = 0; i < 8; i++)
			if (mon[i] && mon_q[i] === 1'b0 && t_rise[i] == 0)
				t_rise[i] <= cyc;
	end
	function automatic logic [7:0] csum(input logic [7:0] h, a, input logic [31:0] d);
		return h + a + d[31:24] + d[23:16] + d[15:8] + d[7:0];
	endfunction
	function automatic string frm(input logic [7:0] h, a, input logic [31:0] d);
		string s = $sformatf("@%h%h%h%h!", h, a, d, csum(h, a, d));
		return s.toupper();
	endfunction
	task automatic chk(input string n, input logic [31:0] e, g);
		checked++;
		if (g !== e) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic xs(input string n, s, e);
		string r;
		host_u.xchg(s, r);
		checked++;
		if (r != e) begin
			error_cnt++;
			$display("Error %s expected %s seen %s", n, e, r);
		end
	endtask
	// Sends a well-formed command, expects an accepted reply carrying e
	task automatic cmd(input logic [7:0] h, a, input logic [31:0] d, e);
		xs($sformatf("reply %h %h", h, a), frm(h, a, d), frm(8'h00, a, e));
	endtask
	task automatic done(input string n);
		$display("Test %s done", n);
	endtask
	task automatic wrap_up;
		$display("Comparisons %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// Watchdog well past the timing scenario
	initial begin
		#900000;
		error_cnt++;
		wrap_up();
	end
	initial begin
		repeat (4) @(posedge clk);
		#1 rst = 1'b0;
		chk("mcu sel", 1'b1, console_sel_mcu);
		chk("busy", 1'b0, busy);
		cmd(8'h01, 8'h03, 32'hA5A5_A5A5, 32'h0000_15B4);
		cmd(8'h01, 8'h04, 32'h0000_0000, 32'h000F_FFFF);
		cmd(8'h01, 8'hFF, 32'h0000_0000, `CTR_FW_DATE_CODE);
		done("reset values");
		// Writes of all ones, read back through the field masks
		for (int i = 0; i < 7; i++) begin
			cmd(8'h02, wa[i], 32'hFFFF_FFFF, 32'hFFFF_FFFF);
			cmd(8'h01, wa[i], 32'h0000_0000, wm[i]);
		end
		chk("power", 4'hF, cam_power);
		done("register masks");
		host_u.slow = 1'b1;
		xs("short", "@01020304!", "@01000000000001!");
		xs("bad sum", "@01010000000003!", "@01000000000001!");
		xs("bad hdr", frm(8'h03, 8'h01, 32'h0000_0000), "@01000000000001!");
		xs("restart", "@0@01010000000002!", frm(8'h00, 8'h01, 32'h0000_0000));
		xs("non hex", "@01010000000G02!", "@01000000000001!");
		xs("long", "@0101000000000002FF!", "@01000000000001!");
		xs("lower", "@01ff0000000000!", frm(8'h00, 8'hFF, `CTR_FW_DATE_CODE));
		cmd(8'h00, 8'h05, 32'h1234_5678, 32'h0000_0000);
		host_u.slow = 1'b0;
		done("errors");
		@(posedge clk);
		#1 trigger_sources = 4'h4;
		@(posedge clk);
		#1 trigger_sources = 4'h0;
		chk("busy set", 1'b1, busy);
		cmd(8'h01, 8'h00, 32'h0000_0000, 32'h0000_0002);
		cmd(8'h02, 8'h00, 32'h0000_0002, 32'h0000_0002);
		chk("busy clr", 1'b0, busy);
		done("busy");
		for (int i = 0; i < 5; i++) begin
			@(posedge clk);
			#1 console_select_pins = (i < 4) ? 4'h8 + 4'(i) : 4'h3;
			repeat (3) @(posedge clk);
			#1 chk("console cam", (i < 4) ? 4'h1 << i : 4'h0, console_sel_cam);
			chk("console mcu", i == 4, console_sel_mcu);
		end
		done("console");
		for (int i = 0; i < 7; i++)
			cmd(8'h02, ca[i], cd[i], cd[i]);
		cmd(8'h02, 8'hFE, 32'h0000_0005, 32'h0000_0005);
		chk("power", 4'h5, cam_power);
		chk("busy manual", 1'b1, busy);
		// Camera 2 falls due before global enable is turned on
		while (cyc < 27000) @(posedge clk);
		cmd(8'h02, 8'h00, 32'h0000_0001, 32'h0000_0001);
		while (cyc < 36000) @(posedge clk);
		chk("acq offset", 32'h0000_03E8, t_rise[1] - t_rise[0]);
		chk("flash delay", 32'h0000_012C, t_rise[4] - t_rise[0]);
		chk("flash width", 32'h0000_00C8, t_rise[5] - t_rise[4]);
		chk("acq2 gated", 32'h0000_0000, t_rise[2]);
		chk("acq3 off", 32'h0000_0000, t_rise[3]);
		chk("flash1 off", 32'h0000_0000, t_rise[6]);
		chk("manual", 1'b1, t_rise[7] != 0);
		done("timing");
		wrap_up();
	end
endmodule
